// File: verilog/arlf_pkg.sv
// Purpose: Shared constants of the receive log FIFO block
// Assumes: Byte-wide register space with 16-bit addresses
// Notes: Master control, threshold, channel control and pending offsets are local

package arlf_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] FILT_FIRST = 16'h6800;
  localparam logic [15:0] FILT_LAST = 16'h69FF;
  localparam logic [15:0] MEM_FIRST = 16'h7000;
  localparam logic [15:0] MEM_LAST = 16'h7FFF;
  localparam logic [15:0] ADDR_MASTER = 16'h8000;
  localparam logic [15:0] ADDR_FLAG_LO = 16'h800D;
  localparam logic [15:0] ADDR_FLAG_HI = 16'h800E;
  localparam logic [15:0] ADDR_WRAP = 16'h8049;
  localparam logic [15:0] ADDR_IRQ_EN_LO = 16'h804D;
  localparam logic [15:0] ADDR_IRQ_EN_HI = 16'h804E;
  localparam logic [15:0] COUNT_FIRST = 16'h8068;
  localparam logic [15:0] COUNT_LAST = 16'h8077;
  localparam logic [15:0] THR_FIRST = 16'h8078;
  localparam logic [15:0] THR_LAST = 16'h8087;
  localparam logic [15:0] RXC_FIRST = 16'h8088;
  localparam logic [15:0] RXC_LAST = 16'h8097;
  localparam logic [15:0] ADDR_PENDING = 16'h8098;
  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int MC_RX_EN_BIT = 0;
  localparam int MC_TX_SUPP_BIT = 1;
  localparam int MC_FLIP_BIT = 2;
  localparam int RXC_FIFO_IRQ_BIT = 6;
  localparam int PEND_FIFO_BIT = 0;
  localparam logic [7:0] FLUSH_CODE = 8'hA5;
  localparam logic [6:0] THR_FULL = 7'h7F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Serial commands: op[31:24] addr[23:8] data[7:0]
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h02;
  localparam logic [7:0] OP_FIFO_READ = 8'h03;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1F;
endpackage : arlf_pkg

// File: verilog/arlf_cmd_if.sv
// Purpose: Command and answer carrier between serial link and core
// Assumes: cmd is stable between two toggles of req_tgl
// Notes: resp is quasi-static; it changes only after a request

`timescale 1ns/10ps

interface arlf_cmd_if;
  logic [31:0] cmd;
  logic req_tgl;
  logic [31:0] resp;
  modport link (output cmd, output req_tgl, input resp);
  modport core (input cmd, input req_tgl, output resp);
endinterface : arlf_cmd_if

// File: verilog/arlf_spi_link.sv
// Purpose: Serial host port, 32-bit frames, mode 0, MSB first
// Assumes: Clock runs only inside frames, whole frames only
// Notes: Answer of a frame is shifted out during the next frame

`timescale 1ns/10ps

module arlf_spi_link (
  input wire logic sck_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  arlf_cmd_if.link bus
);
  logic [1:0] rst_sync;
  logic [4:0] bit_cnt;
  logic [30:0] shift;

  always_ff @(posedge sck_in) begin
    rst_sync <= {rst_sync[0], rst_n_in};
  end

  always_ff @(posedge sck_in) begin
    if (!rst_sync[1]) begin
      bit_cnt <= 5'h00;
      shift <= 31'h0000_0000;
    end else if (!cs_n_in) begin
      bit_cnt <= bit_cnt + 5'h01;
      shift <= {shift[29:0], mosi_in};
    end
  end

  // Last bit of a frame hands the command over by a toggle
  always_ff @(posedge sck_in) begin
    if (!rst_sync[1]) begin
      bus.cmd <= arlf_pkg::RESET_WORD;
      bus.req_tgl <= 1'b0;
    end else if (!cs_n_in && bit_cnt == arlf_pkg::FRAME_LAST_BIT) begin
      bus.cmd <= {shift, mosi_in};
      bus.req_tgl <= ~bus.req_tgl;
    end
  end

  assign miso_out = bus.resp[~bit_cnt];
  assign miso_oe_out = ~cs_n_in;
endmodule : arlf_spi_link

// File: verilog/arlf_fifo.sv
// Purpose: One channel log FIFO that drops its oldest word when full
// Assumes: pop is only acted on when the FIFO holds a word
// Notes: flush wins over push and pop in the same cycle

`timescale 1ns/10ps

module arlf_fifo #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  input wire logic flush_in,
  input wire logic [$clog2(DEPTH)-1:0] peek_idx_in,
  output logic [$clog2(DEPTH):0] count_out,
  output logic [WIDTH-1:0] head_out,
  output logic [WIDTH-1:0] peek_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic full;
  logic do_pop;

  assign full = count_out == FULL_COUNT;
  assign do_pop = pop_in && count_out != '0;
  assign head_out = mem[rd_ptr];
  assign peek_out = mem[AW'(rd_ptr + peek_idx_in)];

  always_ff @(posedge clk_in) begin
    if (ce_in && push_in) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce_in) begin
      if (flush_in) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push_in) begin
          wr_ptr <= wr_ptr + AW'(1);
        end
        if (do_pop || (push_in && full)) begin
          rd_ptr <= rd_ptr + AW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_out <= '0;
    end else if (ce_in) begin
      if (flush_in) begin
        count_out <= '0;
      end else if (push_in && !do_pop && !full) begin
        count_out <= count_out + ONE;
      end else if (do_pop && !push_in) begin
        count_out <= count_out - ONE;
      end
    end
  end

  chk_full_count_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && full && push_in && !flush_in |=> count_out == FULL_COUNT)
    else $error("full FIFO count changed on push");
  chk_flush_empties: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && flush_in |=> count_out == '0)
    else $error("flush did not empty FIFO");
  chk_push_pop_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && push_in && do_pop && !flush_in |=> $stable(count_out))
    else $error("push with pop changed count");
  chk_reset_empty: assert property (@(posedge clk_in)
    !rst_n_in |=> count_out == '0)
    else $error("FIFO not empty after reset");
endmodule : arlf_fifo

// File: verilog/arlf_top.sv
// Purpose: Sixteen receive log FIFOs with filter, flags and self-test wrap
// Assumes: Receivers and transmitters are logic on clk_in; host on serial port
// Notes: Host frames must be spaced by at least six clk_in periods
//
// How it works
// - Sixteen 64-word FIFOs, readable at 0x7000-0x7FFF
// - Filter table at 0x6800, bit per channel/label
// - Word logged only when its filter bit set
// - FIFO read command returns and removes oldest
// - Reset empties FIFOs and clears status registers
// - Flag set when count exceeds threshold
// - Full FIFO drops oldest, count stays 64
// - Seven-bit threshold; all ones means full
// - Read-only flag vector in two bytes
// - Enable vector gates flags onto pending bit
// - Channel control bit 6 also gates interrupt
// - Count register reads words held
// - Writing 0xA5 to count register flushes
// - Wrap bit k feeds receivers 2k, 2k+1 from transmitter k
// - Wrapped pair ignores external receive words
// - Suppress bit blocks external transmit outputs
// - Bus word: label, 23 data, odd parity
// - Stored little-endian, label byte lowest
// - Label flip on receive and before transmit
// - Filter and storage use flipped label
// - Encoding errors rejected, parity errors kept
// - Logging only with receive enable set

`timescale 1ns/10ps

module arlf_top #(
  parameter int NUM_CH = 16,
  parameter int DEPTH = 64
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire logic [NUM_CH-1:0] rx_valid_in,
  input wire logic [NUM_CH*32-1:0] rx_word_in,
  input wire logic [NUM_CH-1:0] rx_code_err_in,
  input wire logic [NUM_CH/2-1:0] tx_valid_in,
  input wire logic [NUM_CH*16-1:0] tx_word_in,
  output logic [NUM_CH/2-1:0] tx_valid_out,
  output logic [NUM_CH*16-1:0] tx_word_out
);
  localparam int NUM_TX = NUM_CH / 2;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = a >= lo && a <= hi;
  endfunction : in_range

  // Label byte reversal, applied on reception and before transmission
  function automatic logic [31:0] flip_label(input logic [31:0] w, input logic en);
    logic [7:0] rev;
    for (int i = 0; i < 8; i++) begin
      rev[i] = w[7-i];
    end
    flip_label = en ? {w[31:8], rev} : w;
  endfunction : flip_label

  // Per-channel register blocks start at low nibble 8, so channel = nibble - 8
  function automatic logic [3:0] reg_slot(input logic [15:0] a);
    reg_slot = a[3:0] - 4'h8;
  endfunction : reg_slot

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] master_ctrl;
  logic [7:0] wrap_sel;
  logic [15:0] fifo_irq_enable_vector;
  logic [6:0] thr [NUM_CH];
  logic [7:0] rx_channel_control [NUM_CH];
  logic [7:0] filt_mem [512];
  logic [NUM_CH-1:0] fifo_level_exceeded_vector;
  logic receive_global_enable;
  logic transmit_output_suppress;
  logic label_flip;
  logic pend_fifo;

  assign receive_global_enable = master_ctrl[arlf_pkg::MC_RX_EN_BIT];
  assign transmit_output_suppress = master_ctrl[arlf_pkg::MC_TX_SUPP_BIT];
  assign label_flip = master_ctrl[arlf_pkg::MC_FLIP_BIT];

  // ----------------------------------------------------------------
  // Host link and command crossing
  // ----------------------------------------------------------------
  arlf_cmd_if cmd_bus ();

  arlf_spi_link u_link (
    .sck_in(spi_sck_in),
    .rst_n_in(rst_n_in),
    .cs_n_in(spi_cs_n_in),
    .mosi_in(spi_mosi_in),
    .miso_out(spi_miso_out),
    .miso_oe_out(spi_miso_oe_out),
    .bus(cmd_bus.link)
  );

  logic [2:0] req_sync;
  logic cmd_go;
  logic [7:0] cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [3:0] cmd_ch;
  logic is_write;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_sync <= 3'h0;
    end else if (ce_in) begin
      req_sync <= {req_sync[1:0], cmd_bus.req_tgl};
    end
  end

  assign cmd_go = ce_in && (req_sync[2] ^ req_sync[1]);
  assign cmd_op = cmd_bus.cmd[31:24];
  assign cmd_addr = cmd_bus.cmd[23:8];
  assign cmd_data = cmd_bus.cmd[7:0];
  assign cmd_ch = cmd_addr[3:0];
  assign is_write = cmd_go && cmd_op == arlf_pkg::OP_WRITE;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] push;
  logic [NUM_CH-1:0] pop;
  logic [NUM_CH-1:0] flush;
  logic [AW:0] count [NUM_CH];
  logic [31:0] head [NUM_CH];
  logic [31:0] peek [NUM_CH];
  logic [31:0] rx_sel [NUM_CH];
  logic [NUM_CH-1:0] irq_gate;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int P = c / 2;
    logic wrapped;
    logic ext_ok;
    logic word_ok;
    logic hit;
    logic [31:0] bus_word;

    assign wrapped = wrap_sel[P];
    // Receiver assembles label first, data, then odd parity; parity errors pass
    assign ext_ok = rx_valid_in[c] && !rx_code_err_in[c];
    assign bus_word = wrapped ? flip_label(tx_word_in[P*32 +: 32], label_flip)
                              : rx_word_in[c*32 +: 32];
    assign word_ok = wrapped ? tx_valid_in[P] : ext_ok;
    assign rx_sel[c] = flip_label(bus_word, label_flip);
    assign hit = filt_mem[{4'(c), rx_sel[c][7:3]}][rx_sel[c][2:0]];
    assign push[c] = receive_global_enable && word_ok && hit;
    assign pop[c] = cmd_go && cmd_op == arlf_pkg::OP_FIFO_READ
                    && cmd_ch == 4'(c);
    assign flush[c] = is_write && cmd_addr == arlf_pkg::COUNT_FIRST + 16'(c)
                      && cmd_data == arlf_pkg::FLUSH_CODE;
    assign irq_gate[c] = rx_channel_control[c][arlf_pkg::RXC_FIFO_IRQ_BIT];

    arlf_fifo #(
      .DEPTH(DEPTH),
      .WIDTH(32)
    ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .push_in(push[c]),
      .push_data_in(rx_sel[c]),
      .pop_in(pop[c]),
      .flush_in(flush[c]),
      .peek_idx_in(cmd_addr[AW+1:2]),
      .count_out(count[c]),
      .head_out(head[c]),
      .peek_out(peek[c])
    );

    // Recomputed from the live count every cycle
    assign fifo_level_exceeded_vector[c] = (thr[c] == arlf_pkg::THR_FULL)
        ? count[c] == FULL_COUNT
        : {1'b0, count[c]} > {1'b0, thr[c]};

    chk_filter_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      push[c] |-> hit && receive_global_enable)
      else $error("word logged without filter bit");
    chk_code_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !wrapped && rx_code_err_in[c] |-> !push[c])
      else $error("badly encoded word logged");
    chk_wrap_ignores: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wrapped && !tx_valid_in[P] |-> !push[c])
      else $error("external word logged while wrapped");
    chk_wrap_feeds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wrapped && tx_valid_in[P] && receive_global_enable && hit |-> push[c])
      else $error("wrapped transmit word not logged");
    chk_flag_tracks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && pop[c] && !push[c] && count[c] == 7'(thr[c]) + 7'h01
        && thr[c] != arlf_pkg::THR_FULL |=> !fifo_level_exceeded_vector[c])
      else $error("flag stayed set after count fell to threshold");
  end

  assign pend_fifo = |(fifo_level_exceeded_vector & fifo_irq_enable_vector
                       & irq_gate);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      master_ctrl <= arlf_pkg::RESET_BYTE;
      wrap_sel <= arlf_pkg::RESET_BYTE;
      fifo_irq_enable_vector <= {2{arlf_pkg::RESET_BYTE}};
    end else if (is_write) begin
      if (cmd_addr == arlf_pkg::ADDR_MASTER) begin
        master_ctrl <= cmd_data;
      end else if (cmd_addr == arlf_pkg::ADDR_WRAP) begin
        wrap_sel <= cmd_data;
      end else if (cmd_addr == arlf_pkg::ADDR_IRQ_EN_LO) begin
        fifo_irq_enable_vector[7:0] <= cmd_data;
      end else if (cmd_addr == arlf_pkg::ADDR_IRQ_EN_HI) begin
        fifo_irq_enable_vector[15:8] <= cmd_data;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        thr[i] <= '0;
        rx_channel_control[i] <= arlf_pkg::RESET_BYTE;
      end
    end else if (is_write) begin
      if (in_range(cmd_addr, arlf_pkg::THR_FIRST, arlf_pkg::THR_LAST)) begin
        thr[reg_slot(cmd_addr)] <= cmd_data[6:0];
      end else if (in_range(cmd_addr, arlf_pkg::RXC_FIRST, arlf_pkg::RXC_LAST)) begin
        rx_channel_control[reg_slot(cmd_addr)] <= cmd_data;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 512; i++) begin
        filt_mem[i] <= arlf_pkg::RESET_BYTE;
      end
    end else if (is_write && in_range(cmd_addr, arlf_pkg::FILT_FIRST,
                                      arlf_pkg::FILT_LAST)) begin
      filt_mem[cmd_addr[8:0]] <= cmd_data;
    end
  end

  // ----------------------------------------------------------------
  // Register reads and answers
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [31:0] peek_word;

  assign peek_word = peek[cmd_addr[11:8]];

  always_comb begin
    rd_byte = arlf_pkg::RESET_BYTE;
    if (cmd_addr == arlf_pkg::ADDR_MASTER) begin
      rd_byte = master_ctrl;
    end else if (cmd_addr == arlf_pkg::ADDR_FLAG_LO) begin
      rd_byte = fifo_level_exceeded_vector[7:0];
    end else if (cmd_addr == arlf_pkg::ADDR_FLAG_HI) begin
      rd_byte = fifo_level_exceeded_vector[15:8];
    end else if (cmd_addr == arlf_pkg::ADDR_WRAP) begin
      rd_byte = wrap_sel;
    end else if (cmd_addr == arlf_pkg::ADDR_IRQ_EN_LO) begin
      rd_byte = fifo_irq_enable_vector[7:0];
    end else if (cmd_addr == arlf_pkg::ADDR_IRQ_EN_HI) begin
      rd_byte = fifo_irq_enable_vector[15:8];
    end else if (cmd_addr == arlf_pkg::ADDR_PENDING) begin
      rd_byte = 8'({pend_fifo}) << arlf_pkg::PEND_FIFO_BIT;
    end else if (in_range(cmd_addr, arlf_pkg::COUNT_FIRST, arlf_pkg::COUNT_LAST)) begin
      rd_byte = 8'(count[reg_slot(cmd_addr)]);
    end else if (in_range(cmd_addr, arlf_pkg::THR_FIRST, arlf_pkg::THR_LAST)) begin
      rd_byte = {1'b0, thr[reg_slot(cmd_addr)]};
    end else if (in_range(cmd_addr, arlf_pkg::RXC_FIRST, arlf_pkg::RXC_LAST)) begin
      rd_byte = rx_channel_control[reg_slot(cmd_addr)];
    end else if (in_range(cmd_addr, arlf_pkg::FILT_FIRST, arlf_pkg::FILT_LAST)) begin
      rd_byte = filt_mem[cmd_addr[8:0]];
    end else if (in_range(cmd_addr, arlf_pkg::MEM_FIRST, arlf_pkg::MEM_LAST)) begin
      rd_byte = peek_word[8*cmd_addr[1:0] +: 8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_bus.resp <= arlf_pkg::RESET_WORD;
    end else if (cmd_go) begin
      if (cmd_op == arlf_pkg::OP_READ) begin
        cmd_bus.resp <= {24'h00_0000, rd_byte};
      end else if (cmd_op == arlf_pkg::OP_FIFO_READ) begin
        cmd_bus.resp <= count[cmd_ch] != '0 ? head[cmd_ch] : arlf_pkg::RESET_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_valid_out <= '0;
      tx_word_out <= '0;
    end else if (ce_in) begin
      for (int k = 0; k < NUM_TX; k++) begin
        tx_valid_out[k] <= tx_valid_in[k] && !transmit_output_suppress;
        tx_word_out[k*32 +: 32] <= flip_label(tx_word_in[k*32 +: 32], label_flip);
      end
    end
  end

  chk_tx_suppress: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && transmit_output_suppress |=> tx_valid_out == '0)
    else $error("transmit output active while suppressed");
  chk_tx_passes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !transmit_output_suppress |=> tx_valid_out == $past(tx_valid_in))
    else $error("transmit valid not passed through");
  chk_rx_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !receive_global_enable |-> push == '0)
    else $error("word logged with receive disabled");
  chk_fifo_read_pops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_go && cmd_op == arlf_pkg::OP_FIFO_READ && count[cmd_ch] != '0
      && !push[cmd_ch] && !flush[cmd_ch]
      |=> count[$past(cmd_ch)] == $past(count[cmd_ch]) - 7'h01)
    else $error("FIFO read did not remove a word");
endmodule : arlf_top

// File: sim/arlf_spi_host.sv
// Purpose: Host model on the serial port of the log FIFO block
// Assumes: 32-bit mode 0 frames, MSB first, 6 ns link clock
// Notes: got_out toggles once a marked answer is complete

`timescale 1ns/10ps

module arlf_spi_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  output logic got_out,
  output logic [31:0] resp_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    got_out = 1'b0;
    resp_out = 32'h0;
  end
  // Whole frame, clock still outside it, then the spacing the core needs
  task automatic xfer(input logic [31:0] cmd, input logic mark);
    cs_n_out = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_out = cmd[i];
      #3 resp_out[i] = miso_in;
      sck_out = 1'b1;
      #3 sck_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    if (mark) got_out = ~got_out;
    #700;
  endtask : xfer
endmodule : arlf_spi_host

// File: sim/tb_arinc_rx_log_fifo_loopback.sv
// Purpose: Self-checking bench of the receive log FIFO block
// Assumes: Answers arrive one frame after their command
// Notes: Expected answers queue up and are matched in order

`timescale 1ns/10ps

module tb_arinc_rx_log_fifo_loopback;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sck, cs_n, mosi, miso, got, oe;
  logic ce = 1'b1;
  logic [31:0] resp, w, w1, w2;
  logic [15:0] rxv = 16'h0;
  logic [15:0] rxe = 16'h0;
  logic [511:0] rxw = '0;
  logic [7:0] txv = 8'h0;
  logic [7:0] txvo;
  logic [255:0] txw = '0;
  logic [255:0] txwo;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 50130;
  logic [31:0] q[$];
  logic [15:0] regs [6] = '{16'h800D, 16'h800E, 16'h8049, 16'h804D, 16'h804E, 16'h806B};
  always #50 clk_in = ~clk_in;
  arlf_top #(.NUM_CH(16), .DEPTH(64)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(oe), .rx_valid_in(rxv), .rx_word_in(rxw),
    .rx_code_err_in(rxe), .tx_valid_in(txv), .tx_word_in(txw),
    .tx_valid_out(txvo), .tx_word_out(txwo));
  arlf_spi_host host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso),
    .got_out(got), .resp_out(resp));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.xfer({arlf_pkg::OP_WRITE, a, d}, 1'b0);
  endtask : wr
  task automatic ask(input logic [7:0] op, input logic [15:0] a, input logic [31:0] exp);
    host.xfer({op, a, 8'h00}, 1'b0);
    q.push_back(exp);
    host.xfer(32'h0, 1'b1);
  endtask : ask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    ask(arlf_pkg::OP_READ, a, exp);
  endtask : rd
  task automatic push(input int ch, input logic [31:0] d, input logic e);
    @(negedge clk_in);
    rxw[ch*32+:32] = d;
    rxv[ch] = 1'b1;
    rxe[ch] = e;
    @(negedge clk_in);
    rxv = 16'h0;
    rxe = 16'h0;
  endtask : push
  task automatic tx(input int k, input logic [31:0] d, input logic v, input logic [31:0] e);
    @(negedge clk_in);
    txw[k*32+:32] = d;
    txv[k] = 1'b1;
    @(negedge clk_in);
    txv = 8'h0;
    chk({31'h0, txvo[k]}, {31'h0, v});
    chk(txwo[k*32+:32], e);
  endtask : tx
  always @(got) if ($time > 0) chk(resp, q.pop_front());
  always @(posedge sck) chk({31'h0, oe}, 32'h1);
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Reset rises just before the last two rising link edges of this frame, so the link's
    // reset synchroniser is clear before the first real frame
    fork
      begin
        #20;
        host.xfer(32'h0, 1'b0);
      end
      begin
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
      end
    join
    chk({31'h0, oe}, 32'h0);
    foreach (regs[i]) rd(regs[i], 32'h0);
    w = $random(seed);
    w[7:0] = 8'h25;
    push(3, w, 1'b0);
    rd(16'h806B, 32'h0);
    wr(arlf_pkg::ADDR_MASTER, 8'h01);
    wr(16'h6864, 8'h20);
    rd(16'h6864, 32'h20);
    push(3, w, 1'b0);
    w2 = {w[31:8], 8'h26};
    push(3, w2, 1'b0);
    push(3, ~w, 1'b1);
    rd(16'h806B, 32'h1);
    rd(arlf_pkg::ADDR_FLAG_LO, 32'h8);
    wr(arlf_pkg::ADDR_IRQ_EN_LO, 8'h08);
    rd(arlf_pkg::ADDR_PENDING, 32'h0);
    wr(16'h808B, 8'h40);
    rd(arlf_pkg::ADDR_PENDING, 32'h1);
    ask(arlf_pkg::OP_FIFO_READ, 16'h0003, w);
    rd(arlf_pkg::ADDR_FLAG_LO, 32'h0);
    for (int i = 0; i < 65; i++) begin
      w1 = $random(seed);
      w1[7:0] = 8'h25;
      if (i == 1) w = w1;
      push(3, w1, 1'b0);
    end
    rd(16'h806B, 32'h40);
    wr(16'h807B, 8'h7F);
    rd(arlf_pkg::ADDR_FLAG_LO, 32'h8);
    ask(arlf_pkg::OP_FIFO_READ, 16'h0003, w);
    rd(arlf_pkg::ADDR_FLAG_LO, 32'h0);
    wr(16'h806B, arlf_pkg::FLUSH_CODE);
    rd(16'h806B, 32'h0);
    @(negedge clk_in);
    ce = 1'b0;
    push(3, w, 1'b0);
    @(negedge clk_in);
    ce = 1'b1;
    rd(16'h806B, 32'h0);
    tx(1, w, 1'b1, w);
    wr(arlf_pkg::ADDR_MASTER, 8'h03);
    wr(arlf_pkg::ADDR_WRAP, 8'h02);
    tx(1, w, 1'b0, w);
    push(3, w1, 1'b0);
    rd(16'h806B, 32'h1);
    ask(arlf_pkg::OP_FIFO_READ, 16'h0003, w);
    wr(arlf_pkg::ADDR_WRAP, 8'h00);
    wr(arlf_pkg::ADDR_MASTER, 8'h05);
    w[7:0] = 8'hA4;
    push(3, w, 1'b0);
    ask(arlf_pkg::OP_FIFO_READ, 16'h0003, {w[31:8], 8'h25});
    tx(1, {w[31:8], 8'h25}, 1'b1, w);
    end_sim();
  end
endmodule : tb_arinc_rx_log_fifo_loopback
